// ---- logic/stc_top.sv ----
// Purpose: status byte, service request, trigger and common commands
// Assumes: commands arrive decoded as one-cycle strobes on CMD_*
// Notes:   setpoints and levels are 16-bit codes
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_top (
    input  wire logic            MCLK_I,        // Clock 125 MHz
    input  wire logic            RST_B_I,       // Reset, active low
    input  wire logic            CMD_VLD_I,     // Command strobe
    input  stc_pkg::stc_cmd_t    CMD_I,         // Command code
    input  wire logic [7:0]      CMD_ARG_I,     // Command argument
    output logic                 CMD_RDY_O,     // Command may be taken
    output logic                 ERR_RANGE_O,   // Bad index pulse
    input  wire logic            SPOLL_I,       // Serial poll strobe
    input  wire logic            LISTEN_I,      // Addressed listener pin
    input  wire logic            GET_I,         // Group execute trigger
    input  wire logic            OPER_SUM_I,    // Operation summary
    input  wire logic            MAV_I,         // Message available
    input  wire logic            QUES_SUM_I,    // Questionable summary
    input  wire logic            ERRQ_I,        // error_queue_nonempty
    input  wire logic            BUSY_I,        // Prior work pending
    input  wire logic [7:0]      EVT_SET_I,     // Event set pulses
    input  wire logic [7:0]      EVT_EN_I,      // Event enable mask
    input  wire logic            SYNC_MODE_I,   // Synchronized measure
    input  wire logic            SP_VALID_I,    // Setpoint data valid
    input  wire logic            RST_OUT_ON_I,  // Output state after reset command
    input  wire logic [7:0]      TST_FAIL_I,    // Subtest fail bits
    input  wire logic            SP_WR_I,       // Setpoint write strobe
    input  wire logic [15:0]     SP_VOLT_I,     // New voltage setpoint
    input  wire logic [15:0]     SP_CURR_I,     // New current setpoint
    input  wire logic [15:0]     TRIG_VOLT_I,   // Trigger voltage level
    input  wire logic [15:0]     TRIG_CURR_I,   // Trigger current level
    input  stc_pkg::stc_src_t    TRIG_SRC_I,    // Trigger source
    input  wire logic            OUT_WR_I,      // Output switch strobe
    input  wire logic            OUT_ON_I,      // Output switch value
    input  wire logic            FUNC_CURR_I,   // Function current when set
    output logic [7:0]           RESP_O,        // Query response byte
    output logic                 RESP_VLD_O,    // Response pulse
    output logic                 RESP_LAST_O,   // Last response byte
    output logic [7:0]           STB_O,         // status_summary_byte
    output logic                 SRQ_O,         // Request service level
    output logic                 WTG_O,         // waiting_for_trigger
    output logic                 LIST_RUN_O,    // List running
    output logic                 TRIG_O,        // Trigger pulse
    output logic                 OUT_ON_O,      // Output enabled
    output logic [15:0]          VOLT_O,        // Applied voltage
    output logic [15:0]          CURR_O,        // Applied current
    output logic [15:0]          VPROT_O,       // Voltage protection
    output logic [15:0]          CPROT_O,       // Current protection
    output logic                 FUNC_CURR_O,   // Function current mode
    output logic                 MAIN_EXT_O,    // Main reference external
    output logic                 PROT_EXT_O,    // Protect reference external
    output logic                 CONT_O,        // Continuous arming
    output logic                 TRIG_LVL0_O    // Trigger levels zeroed
);
    // -------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------
    logic [1:0] lsn_q;
    logic [1:0] get_q;
    logic       get_d1_q;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lsn_q    <= 2'h0;
            get_q    <= 2'h0;
            get_d1_q <= 1'b0;
        end else begin
            lsn_q    <= {lsn_q[0], LISTEN_I};
            get_q    <= {get_q[0], GET_I};
            get_d1_q <= get_q[1];
        end
    end
    logic get_rise;
    assign get_rise = get_q[1] & ~get_d1_q;

    // -------------------------------------------------------------
    // Command acceptance and wait
    // -------------------------------------------------------------
    logic wai_q;
    logic cmd_go;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wai_q <= 1'b0;
        end else if (wai_q) begin
            if (!BUSY_I && (!SYNC_MODE_I || SP_VALID_I)) begin
                wai_q <= 1'b0;
            end
        end else if (cmd_go && CMD_I == stc_pkg::STC_CMD_WAI) begin
            wai_q <= 1'b1;
        end
    end
    assign CMD_RDY_O = ~wai_q;
    assign cmd_go    = CMD_VLD_I & ~wai_q;
    function automatic logic is_cmd(input stc_pkg::stc_cmd_t c);
        is_cmd = cmd_go && (CMD_I == c);
    endfunction

    logic idx_ok;
    assign idx_ok = CMD_ARG_I[7] == 1'b0 && CMD_ARG_I[6:0] >= `STC_MEM_MIN
                    && CMD_ARG_I[6:0] <= `STC_MEM_MAX;
    logic rst_cmd;
    assign rst_cmd = is_cmd(stc_pkg::STC_CMD_RST);

    // -------------------------------------------------------------
    // Service request mask and event register
    // -------------------------------------------------------------
    logic [7:0] sre_q;
    logic [7:0] esr_q;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sre_q <= `STC_ZERO8;
        end else if (is_cmd(stc_pkg::STC_CMD_SRE_WR)) begin
            sre_q <= CMD_ARG_I & `STC_SRE_RW_MASK;
        end
    end
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            esr_q <= `STC_ZERO8;
        end else if (is_cmd(stc_pkg::STC_CMD_ESR_RD)) begin
            esr_q <= EVT_SET_I;
        end else begin
            esr_q <= esr_q | EVT_SET_I;
        end
    end

    // -------------------------------------------------------------
    // Status byte
    // -------------------------------------------------------------
    logic [7:0] stb_raw;
    logic       mss;
    logic       rqs_q;
    logic       mss_d1_q;
    always_comb begin
        stb_raw                = `STC_ZERO8;
        stb_raw[`STC_SB_OPER]  = OPER_SUM_I;
        stb_raw[`STC_SB_ESB]   = |(esr_q & EVT_EN_I);
        stb_raw[`STC_SB_MAV]   = MAV_I;
        stb_raw[`STC_SB_QUES]  = QUES_SUM_I;
        stb_raw[`STC_SB_ERRQ]  = ERRQ_I;
        stb_raw[`STC_SB_LRUN]  = LIST_RUN_O;
        stb_raw[`STC_SB_BUSY]  = BUSY_I;
    end
    assign mss = |(stb_raw & sre_q);
    // poll clears request, rising summary sets it
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rqs_q    <= 1'b0;
            mss_d1_q <= 1'b0;
        end else begin
            mss_d1_q <= mss;
            if (mss && !mss_d1_q) begin
                rqs_q <= 1'b1;
            end else if (SPOLL_I || !mss) begin
                rqs_q <= 1'b0;
            end
        end
    end
    always_comb begin
        STB_O              = stb_raw;
        STB_O[`STC_SB_RQS] = mss;
    end
    assign SRQ_O = rqs_q;

    // -------------------------------------------------------------
    // Trigger system
    // -------------------------------------------------------------
    logic cont_q;
    logic arm_q;
    logic out_on_q;
    logic trg_req;
    logic trg_fire;
    assign trg_req  = (is_cmd(stc_pkg::STC_CMD_TRG) || get_rise) && lsn_q[1];
    assign trg_fire = trg_req && arm_q && WTG_O && out_on_q
                      && TRIG_SRC_I == stc_pkg::STC_SRC_BUS;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cont_q <= 1'b0;
            arm_q  <= 1'b0;
        end else if (rst_cmd) begin
            cont_q <= 1'b0;
            arm_q  <= 1'b0;
        end else if (is_cmd(stc_pkg::STC_CMD_CONT)) begin
            cont_q <= CMD_ARG_I[0];
            arm_q  <= CMD_ARG_I[0] | arm_q;
        end else if (is_cmd(stc_pkg::STC_CMD_INIT)) begin
            arm_q <= 1'b1;
        end else if (trg_fire) begin
            arm_q <= cont_q;
        end
    end
    assign WTG_O   = arm_q;
    assign CONT_O  = cont_q;
    assign TRIG_O  = trg_fire;

    // -------------------------------------------------------------
    // Settings, save and recall
    // -------------------------------------------------------------
    logic [15:0] volt_q;
    logic [15:0] curr_q;
    logic [15:0] vprot_q;
    logic [15:0] cprot_q;
    logic        func_q;
    logic        main_ext_q;
    logic        prot_ext_q;
    logic        lrun_q;
    logic        lvl0_q;
    logic        rcl_pend_q;
    logic [35:0] rec_rd;
    logic [35:0] rec_wr;
    logic [15:0] sp_main;
    logic [15:0] sp_prot;
    assign sp_main = func_q ? curr_q : volt_q;
    assign sp_prot = func_q ? vprot_q : cprot_q;
    assign rec_wr  = {func_q, main_ext_q, prot_ext_q, out_on_q, sp_main, sp_prot};

    stc_setmem #(
        .DW    (36),
        .AW    (7),
        .DEPTH (100)
    ) u_mem (
        .MCLK_I  (MCLK_I),
        .wr_i    (is_cmd(stc_pkg::STC_CMD_SAV) && idx_ok),
        .addr_i  (CMD_ARG_I[6:0]),
        .wdata_i (rec_wr),
        .rdata_o (rec_rd)
    );

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rcl_pend_q <= 1'b0;
        end else begin
            rcl_pend_q <= is_cmd(stc_pkg::STC_CMD_RCL) && idx_ok;
        end
    end
    assign ERR_RANGE_O = (is_cmd(stc_pkg::STC_CMD_SAV) || is_cmd(stc_pkg::STC_CMD_RCL))
                         && !idx_ok;

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            volt_q     <= `STC_LVL_ZERO;
            curr_q     <= `STC_LVL_ZERO;
            vprot_q    <= `STC_PROT_MAX;
            cprot_q    <= `STC_PROT_MAX;
            func_q     <= 1'b0;
            main_ext_q <= 1'b0;
            prot_ext_q <= 1'b0;
            out_on_q   <= 1'b0;
            lrun_q     <= 1'b0;
            lvl0_q     <= 1'b1;
        end else if (rst_cmd) begin
            volt_q     <= `STC_LVL_ZERO;
            curr_q     <= `STC_LVL_ZERO;
            vprot_q    <= `STC_PROT_MAX;
            cprot_q    <= `STC_PROT_MAX;
            func_q     <= 1'b0;
            main_ext_q <= 1'b0;
            prot_ext_q <= 1'b0;
            out_on_q   <= RST_OUT_ON_I;
            lrun_q     <= 1'b0;
            lvl0_q     <= 1'b1;
        end else if (rcl_pend_q) begin
            func_q     <= rec_rd[35];
            main_ext_q <= rec_rd[34];
            prot_ext_q <= rec_rd[33];
            out_on_q   <= rec_rd[32];
            if (rec_rd[35]) begin
                curr_q  <= rec_rd[31:16];
                vprot_q <= rec_rd[15:0];
            end else begin
                volt_q  <= rec_rd[31:16];
                cprot_q <= rec_rd[15:0];
            end
        end else if (trg_fire) begin
            volt_q <= TRIG_VOLT_I;
            curr_q <= TRIG_CURR_I;
        end else begin
            if (SP_WR_I) begin
                volt_q <= SP_VOLT_I;
                curr_q <= SP_CURR_I;
                func_q <= FUNC_CURR_I;
            end
            if (OUT_WR_I) begin
                out_on_q <= OUT_ON_I;
            end
            if (TRIG_VOLT_I != `STC_LVL_ZERO || TRIG_CURR_I != `STC_LVL_ZERO) begin
                lvl0_q <= 1'b0;
            end
        end
    end
    assign VOLT_O      = volt_q;
    assign CURR_O      = curr_q;
    assign VPROT_O     = vprot_q;
    assign CPROT_O     = cprot_q;
    assign FUNC_CURR_O = func_q;
    assign MAIN_EXT_O  = main_ext_q;
    assign PROT_EXT_O  = prot_ext_q;
    assign OUT_ON_O    = out_on_q;
    assign LIST_RUN_O  = lrun_q;
    assign TRIG_LVL0_O = lvl0_q;

    // -------------------------------------------------------------
    // Self test
    // -------------------------------------------------------------
    logic [7:0] tst_code;
    logic       tst_done;
    stc_selftest u_tst (
        .MCLK_I  (MCLK_I),
        .RST_B_I (RST_B_I),
        .start_i (is_cmd(stc_pkg::STC_CMD_TST) || is_cmd(stc_pkg::STC_CMD_DIAG)),
        .ext_i   (is_cmd(stc_pkg::STC_CMD_DIAG)),
        .fail_i  (TST_FAIL_I),
        .code_o  (tst_code),
        .done_o  (tst_done)
    );

    // -------------------------------------------------------------
    // Query responses
    // -------------------------------------------------------------
    localparam logic [7:0] OPT_STR [0:`STC_OPT_LEN-1] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
    logic [2:0] opt_idx_q;
    logic       opt_busy_q;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            RESP_O      <= `STC_ZERO8;
            RESP_VLD_O  <= 1'b0;
            RESP_LAST_O <= 1'b0;
            opt_idx_q   <= 3'h0;
            opt_busy_q  <= 1'b0;
        end else begin
            RESP_VLD_O  <= 1'b0;
            RESP_LAST_O <= 1'b0;
            if (opt_busy_q) begin
                RESP_O      <= OPT_STR[opt_idx_q];
                RESP_VLD_O  <= 1'b1;
                RESP_LAST_O <= (opt_idx_q == 3'(`STC_OPT_LEN - 1));
                opt_busy_q  <= (opt_idx_q != 3'(`STC_OPT_LEN - 1));
                opt_idx_q   <= opt_idx_q + 3'h1;
            end else if (tst_done) begin
                RESP_O      <= tst_code;
                RESP_VLD_O  <= 1'b1;
                RESP_LAST_O <= 1'b1;
            end else if (SPOLL_I) begin
                RESP_O      <= {stb_raw[7], rqs_q, stb_raw[5:0]};
                RESP_VLD_O  <= 1'b1;
                RESP_LAST_O <= 1'b1;
            end else if (is_cmd(stc_pkg::STC_CMD_STB_RD)) begin
                RESP_O      <= STB_O;
                RESP_VLD_O  <= 1'b1;
                RESP_LAST_O <= 1'b1;
            end else if (is_cmd(stc_pkg::STC_CMD_SRE_RD)) begin
                RESP_O      <= sre_q;
                RESP_VLD_O  <= 1'b1;
                RESP_LAST_O <= 1'b1;
            end else if (is_cmd(stc_pkg::STC_CMD_ESR_RD)) begin
                RESP_O      <= esr_q;
                RESP_VLD_O  <= 1'b1;
                RESP_LAST_O <= 1'b1;
            end else if (is_cmd(stc_pkg::STC_CMD_OPT)) begin
                opt_busy_q <= 1'b1;
                opt_idx_q  <= 3'h0;
            end
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    sequence s_poll;
        SPOLL_I && !(mss && !mss_d1_q);
    endsequence
    AST_SRE_B6: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        !sre_q[6]) else $error("mask bit six set");
    AST_MSS: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        STB_O[6] == |(STB_O & sre_q)) else $error("summary mismatch");
    AST_POLL: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        s_poll |=> !rqs_q) else $error("poll left request");
    AST_STB_Q: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        is_cmd(stc_pkg::STC_CMD_STB_RD) && !opt_busy_q && !tst_done && !SPOLL_I
        |=> RESP_VLD_O && RESP_O == $past(STB_O)) else $error("status query");
    AST_TRG: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        TRIG_O |-> WTG_O && TRIG_SRC_I == stc_pkg::STC_SRC_BUS) else $error("bad trigger");
    AST_OFF: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        !out_on_q |-> !TRIG_O) else $error("trigger while off");
    AST_LSN: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        TRIG_O |-> lsn_q[1]) else $error("trigger unaddressed");
    AST_REARM: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        TRIG_O && !rst_cmd |=> WTG_O == $past(cont_q)) else $error("rearm wrong");
    AST_WAI: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        wai_q && BUSY_I |=> !CMD_RDY_O) else $error("wait released early");
    AST_RST: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        rst_cmd |=> !CONT_O && VOLT_O == `STC_LVL_ZERO && !LIST_RUN_O) else $error("reset");
    AST_TST: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        is_cmd(stc_pkg::STC_CMD_TST) |=> (tst_code & 8'hE0) == 8'h00) else $error("ext bits");
    AST_ESR: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        is_cmd(stc_pkg::STC_CMD_ESR_RD) |=> esr_q == $past(EVT_SET_I)) else $error("esr");
endmodule

// ---- logic/stc_cfg.svh ----
// Purpose: constants for the common-command status and trigger block
// Assumes: included by bare name
// Notes:   bit positions, codes and reset values
`ifndef STC_CFG_SVH
`define STC_CFG_SVH
`define STC_SB_OPER      7
`define STC_SB_RQS       6
`define STC_SB_ESB       5
`define STC_SB_MAV       4
`define STC_SB_QUES      3
`define STC_SB_ERRQ      2
`define STC_SB_LRUN      1
`define STC_SB_BUSY      0
`define STC_ZERO8        8'h00
`define STC_SRE_RW_MASK  8'hBF
`define STC_TST_SELF     8'h17
`define STC_TST_EXT      8'hF7
`define STC_MEM_MIN      7'h01
`define STC_MEM_MAX      7'h63
`define STC_LVL_ZERO     16'h0000
`define STC_PROT_MAX     16'hFFFF
`define STC_OPT_LEN      5
`endif

// ---- logic/stc_pkg.sv ----
// Purpose: shared types for the common-command block
// Assumes: nothing
// Notes:   command codes for the command strobe
package stc_pkg;
    typedef enum logic [3:0] {
        STC_CMD_NONE,
        STC_CMD_SRE_WR,
        STC_CMD_SRE_RD,
        STC_CMD_STB_RD,
        STC_CMD_ESR_RD,
        STC_CMD_TRG,
        STC_CMD_INIT,
        STC_CMD_CONT,
        STC_CMD_TST,
        STC_CMD_DIAG,
        STC_CMD_RST,
        STC_CMD_SAV,
        STC_CMD_RCL,
        STC_CMD_WAI,
        STC_CMD_OPT
    } stc_cmd_t;
    typedef enum logic [1:0] {
        STC_SRC_BUS,
        STC_SRC_IMM,
        STC_SRC_EXT
    } stc_src_t;
endpackage

// ---- logic/stc_setmem.sv ----
// Purpose: nonvolatile-style store of 100 setting records
// Assumes: index already range checked by caller
// Notes:   read data registered, one cycle after request
`timescale 1ns/1ps
module stc_setmem #(
    parameter int DW = 36,
    parameter int AW = 7,
    parameter int DEPTH = 100
) (
    input  wire logic          MCLK_I,   // Clock
    input  wire logic          wr_i,     // Write strobe
    input  wire logic [AW-1:0] addr_i,   // Location
    input  wire logic [DW-1:0] wdata_i,  // Record in
    output logic      [DW-1:0] rdata_o   // Record out
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge MCLK_I) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule

// ---- logic/stc_selftest.sv ----
// Purpose: collects subtest failures into a result code
// Assumes: fail inputs synchronous to MCLK_I
// Notes:   subtest bit 3 never sampled; self mode masks extended bits
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_selftest (
    input  wire logic       MCLK_I,   // Clock
    input  wire logic       RST_B_I,  // Reset, active low
    input  wire logic       start_i,  // Run pulse
    input  wire logic       ext_i,    // Extended diagnostic run
    input  wire logic [7:0] fail_i,   // Subtest fail bits
    output logic      [7:0] code_o,   // Result code
    output logic            done_o    // Result valid pulse
);
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            code_o <= `STC_ZERO8;
            done_o <= 1'b0;
        end else begin
            done_o <= start_i;
            if (start_i) begin
                code_o <= fail_i & (ext_i ? `STC_TST_EXT : `STC_TST_SELF);
            end
        end
    end
endmodule

// ---- testbench/stc_ctrl_model.sv ----
// Purpose: bus controller model issuing commands and serial polls
// Assumes: signals change at the falling edge
// Notes:   a command is held until ready is sampled high
`timescale 1ns/1ps
module stc_ctrl_model (
    input  wire logic         clk_i,    // Clock
    input  wire logic         rdy_i,    // Command may be taken
    output logic              vld_o,    // Command strobe
    output stc_pkg::stc_cmd_t cmd_o,    // Command code
    output logic [7:0]        arg_o,    // Command argument
    output logic              spoll_o   // Serial poll strobe
);
    initial begin
        vld_o = 1'b0;
        cmd_o = stc_pkg::STC_CMD_NONE;
        arg_o = 8'h00;
        spoll_o = 1'b0;
    end
    task automatic send(input stc_pkg::stc_cmd_t c, input logic [7:0] a);
        @(negedge clk_i);
        vld_o = 1'b1;
        cmd_o = c;
        arg_o = a;
        @(posedge clk_i);
        while (rdy_i !== 1'b1) @(posedge clk_i);
        @(negedge clk_i);
        vld_o = 1'b0;
        cmd_o = stc_pkg::STC_CMD_NONE;
        // Released argument shows no stale value
        arg_o = ~a;
    endtask
    task automatic poll();
        @(negedge clk_i);
        spoll_o = 1'b1;
        @(negedge clk_i);
        spoll_o = 1'b0;
    endtask
endmodule

// ---- testbench/status_trigger_common_cmds_test.sv ----
// Purpose: self-checking bench for the common-command block
// Assumes: inputs driven at the falling edge
// Notes:   responses taken at the falling edge after they rise
`timescale 1ns/1ps
module status_trigger_common_cmds_test;
    logic MCLK_I = 1'b0, RST_B_I = 1'b0, CMD_VLD_I, CMD_RDY_O, ERR_RANGE_O, SPOLL_I;
    logic LISTEN_I = 1'b1, GET_I = 1'b0, OPER_SUM_I = 1'b0, MAV_I = 1'b0, QUES_SUM_I = 1'b0;
    logic ERRQ_I = 1'b0, BUSY_I = 1'b0, SYNC_MODE_I = 1'b0, SP_VALID_I = 1'b1;
    logic RST_OUT_ON_I = 1'b0, SP_WR_I = 1'b0, OUT_WR_I = 1'b0, OUT_ON_I = 1'b0;
    logic FUNC_CURR_I = 1'b0, RESP_VLD_O, RESP_LAST_O, SRQ_O, WTG_O, LIST_RUN_O, TRIG_O;
    logic OUT_ON_O, FUNC_CURR_O, MAIN_EXT_O, PROT_EXT_O, CONT_O, TRIG_LVL0_O, trig_seen, err_seen;
    logic [7:0] CMD_ARG_I, EVT_SET_I = 8'h00, EVT_EN_I = 8'h00, TST_FAIL_I = 8'hFF;
    logic [7:0] RESP_O, STB_O, r;
    logic [15:0] SP_VOLT_I = 16'h0000, SP_CURR_I = 16'h0000, TRIG_VOLT_I = 16'h1234;
    logic [15:0] TRIG_CURR_I = 16'h0056, VOLT_O, CURR_O, VPROT_O, CPROT_O;
    stc_pkg::stc_cmd_t CMD_I;
    stc_pkg::stc_src_t TRIG_SRC_I = stc_pkg::STC_SRC_BUS;
    int n_mismatch = 0, n_tests = 0;
    always #4 MCLK_I = ~MCLK_I;
    stc_top u_stc_top (.*);
    stc_ctrl_model u_stc_ctrl_model (.clk_i(MCLK_I), .rdy_i(CMD_RDY_O), .vld_o(CMD_VLD_I),
        .cmd_o(CMD_I), .arg_o(CMD_ARG_I), .spoll_o(SPOLL_I));
    always @(posedge MCLK_I) if (TRIG_O === 1'b1) trig_seen <= 1'b1;
    always @(posedge MCLK_I) if (ERR_RANGE_O === 1'b1) err_seen <= 1'b1;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic get_resp(output logic [7:0] v);
        v = 8'hXX;
        for (int i = 0; i < 8; i++) begin
            if (RESP_VLD_O === 1'b1) begin
                v = RESP_O;
                break;
            end
            @(negedge MCLK_I);
        end
    endtask
    task automatic q(input stc_pkg::stc_cmd_t c, input logic [7:0] a, input logic [7:0] e,
                     input string nm);
        u_stc_ctrl_model.send(c, a);
        get_resp(r);
        chk(nm, {8'h00, e}, {8'h00, r});
    endtask
    task automatic t_status();
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_SRE_WR, 8'hFF);
        q(stc_pkg::STC_CMD_SRE_RD, 8'h00, 8'hBF, "sre");
        MAV_I = 1'b1;
        q(stc_pkg::STC_CMD_STB_RD, 8'h00, 8'h50, "stb");
        u_stc_ctrl_model.poll();
        get_resp(r);
        chk("poll", 16'h0050, {8'h00, r});
        @(negedge MCLK_I);
        chk("srq", 16'h0000, {15'h0000, SRQ_O});
        chk("mss", 16'h0050, {8'h00, STB_O});
        MAV_I = 1'b0;
        @(negedge MCLK_I);
        chk("stb_clr", 16'h0000, {8'h00, STB_O});
    endtask
    task automatic t_trigger();
        OUT_ON_I = 1'b1;
        OUT_WR_I = 1'b1;
        @(negedge MCLK_I);
        OUT_WR_I = 1'b0;
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_INIT, 8'h00);
        chk("wtg", 16'h0001, {15'h0000, WTG_O});
        trig_seen = 1'b0;
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_TRG, 8'h00);
        chk("trig", 16'h0001, {15'h0000, trig_seen});
        chk("volt", 16'h1234, VOLT_O);
        chk("wtg_clr", 16'h0000, {15'h0000, WTG_O});
        trig_seen = 1'b0;
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_TRG, 8'h00);
        chk("unarmed", 16'h0000, {15'h0000, trig_seen});
    endtask
    task automatic t_esr();
        EVT_EN_I = 8'h20;
        EVT_SET_I = 8'h20;
        @(negedge MCLK_I);
        EVT_SET_I = 8'h00;
        chk("esb", 16'h0060, {8'h00, STB_O});
        q(stc_pkg::STC_CMD_ESR_RD, 8'h00, 8'h20, "esr");
        q(stc_pkg::STC_CMD_ESR_RD, 8'h00, 8'h00, "esr_clr");
    endtask
    task automatic t_wait();
        BUSY_I = 1'b1;
        SYNC_MODE_I = 1'b1;
        SP_VALID_I = 1'b0;
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_WAI, 8'h00);
        BUSY_I = 1'b0;
        chk("wai", 16'h0, {15'h0, CMD_RDY_O});
        @(negedge MCLK_I);
        chk("wai_sync", 16'h0, {15'h0, CMD_RDY_O});
        SP_VALID_I = 1'b1;
        @(negedge MCLK_I);
        chk("wai_go", 16'h1, {15'h0, CMD_RDY_O});
        SYNC_MODE_I = 1'b0;
    endtask
    task automatic t_mem();
        err_seen = 1'b0;
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_SAV, 8'h64);
        chk("range", 16'h1, {15'h0, err_seen});
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_SAV, 8'h05);
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_RST, 8'h00);
        chk("rst_v", 16'h0000, VOLT_O);
        chk("rst_p", 16'hFFFF, CPROT_O);
        chk("rst_l", 16'h1, {15'h0, TRIG_LVL0_O});
        chk("rst_o", 16'h0, {15'h0, OUT_ON_O});
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_RCL, 8'h05);
        @(negedge MCLK_I);
        chk("rcl_v", 16'h1234, VOLT_O);
        chk("rcl_o", 16'h1, {15'h0, OUT_ON_O});
    endtask
    task automatic t_cont();
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_CONT, 8'h01);
        trig_seen = 1'b0;
        GET_I = 1'b1;
        repeat (4) @(negedge MCLK_I);
        GET_I = 1'b0;
        chk("get", 16'h1, {15'h0, trig_seen});
        chk("rearm", 16'h1, {15'h0, WTG_O});
        chk("cont", 16'h1, {15'h0, CONT_O});
        OUT_ON_I = 1'b0;
        OUT_WR_I = 1'b1;
        @(negedge MCLK_I);
        OUT_WR_I = 1'b0;
        trig_seen = 1'b0;
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_TRG, 8'h00);
        chk("off", 16'h0, {15'h0, trig_seen});
    endtask
    task automatic t_opt();
        u_stc_ctrl_model.send(stc_pkg::STC_CMD_OPT, 8'h00);
        for (int i = 0; i < 5; i++) begin
            get_resp(r);
            chk("opt", {8'h00, 8'h41 + i[7:0]}, {8'h00, r});
            chk("opt_last", {15'h0, i == 4}, {15'h0, RESP_LAST_O});
            @(negedge MCLK_I);
        end
    endtask
    task automatic report_and_stop();
        $display("n_tests=%0d n_mismatch=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(negedge MCLK_I);
        RST_B_I = 1'b1;
        t_status();
        t_trigger();
        q(stc_pkg::STC_CMD_TST, 8'h00, 8'h17, "tst");
        q(stc_pkg::STC_CMD_DIAG, 8'h00, 8'hF7, "diag");
        t_esr();
        t_wait();
        t_mem();
        t_cont();
        t_opt();
        report_and_stop();
    end
endmodule
